// ===== rtl/pdmc_top.sv
// power-down mode controller with axi4-lite system control register
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
module pdmc_top
    import pdmc_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // cpu side
    input  wire logic        sleep_exec,
    input  wire logic        cpu_mask_flag,
    output logic             wake_irq,
    output logic             wake_reset,
    // interrupt sources, already gated by their enable bits
    input  wire pdmc_wake_s  wake_src,
    // external pins
    input  wire logic        standby_pin_n,
    input  wire logic        reset_pin_n,
    // chip gating
    output pdmc_ctrl_s       ctrl,
    output pdmc_state_e      mode
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // settle select to state count; 11x is forbidden, treated as longest
    function automatic logic [SETTLE_W-1:0] settle_count(input logic [2:0] sel);
        logic [SETTLE_W-1:0] c;
        c = SETTLE_W'(SETTLE_STATES_4);
        unique case (sel)
            3'h0: c = SETTLE_W'(SETTLE_STATES_0);
            3'h1: c = SETTLE_W'(SETTLE_STATES_1);
            3'h2: c = SETTLE_W'(SETTLE_STATES_2);
            3'h3: c = SETTLE_W'(SETTLE_STATES_3);
            default: c = SETTLE_W'(SETTLE_STATES_4);
        endcase
        return c;
    endfunction : settle_count

    // ------------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------------
    pdmc_state_e         state_ff;
    pdmc_state_e         nxt_state;
    logic                standby_pin_en_ff;
    logic [2:0]          settle_sel_ff;
    logic                nmi_edge_ff;
    logic                host_if_ff;
    logic                ram_en_ff;
    logic                ext_rst_ff;
    logic                mask_at_sleep_ff;
    logic [SETTLE_W-1:0] settle_cnt_ff;
    logic                aw_hold_ff;
    logic                w_hold_ff;
    logic [15:0]         awaddr_ff;
    logic [31:0]         wdata_ff;
    logic [3:0]          wstrb_ff;
    logic                bvalid_ff;
    logic [1:0]          bresp_ff;
    logic                rvalid_ff;
    logic [31:0]         rdata_ff;
    logic [1:0]          rresp_ff;
    logic                wr_fire;
    logic                sw_wake;
    logic                sleep_wake;
    logic [7:0]          sysctl_rd;

    // ------------------------------------------------------------------
    // wake decoding
    // ------------------------------------------------------------------
    // masked sleep: only nmi wakes; peripheral requests arrive pre-gated
    assign sleep_wake = wake_src.nmi
                      | (!mask_at_sleep_ff & (|wake_src.ext_irq | |wake_src.key_sense
                                              | wake_src.periph_irq));
    // software standby exits on external sources only, clock domain dead
    assign sw_wake = wake_src.nmi | |wake_src.ext_irq | |wake_src.key_sense;

    // ------------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (!standby_pin_n) begin
            nxt_state = PDMC_HSTBY;
        end else begin
            unique case (state_ff)
                PDMC_RUN: begin
                    if (!reset_pin_n) nxt_state = PDMC_RESET;
                    else if (sleep_exec) nxt_state = standby_pin_en_ff ? PDMC_SSTBY : PDMC_SLEEP;
                end
                PDMC_SLEEP: begin
                    if (!reset_pin_n) nxt_state = PDMC_RESET;
                    else if (sleep_wake) nxt_state = PDMC_RUN;
                end
                PDMC_SSTBY: begin
                    if (!reset_pin_n) nxt_state = PDMC_RESET;
                    else if (sw_wake) nxt_state = PDMC_SETTLE;
                end
                PDMC_SETTLE: begin
                    if (!reset_pin_n) nxt_state = PDMC_RESET;
                    else if (settle_cnt_ff == '0) nxt_state = PDMC_RUN;
                end
                // leaving hardware standby always passes through the reset state, reset pin not sampled here
                PDMC_HSTBY: nxt_state = PDMC_RESET;
                PDMC_RESET: begin
                    if (reset_pin_n) nxt_state = PDMC_RUN;
                end
                default: nxt_state = PDMC_RESET;
            endcase
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) state_ff <= PDMC_RUN;
        else state_ff <= nxt_state;
    end

    // settling counter loads only on interrupt wake from software standby
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_cnt_ff <= '0;
        end else if (state_ff == PDMC_SSTBY && nxt_state == PDMC_SETTLE) begin
            settle_cnt_ff <= settle_count(settle_sel_ff) - SETTLE_W'(1);
        end else if (state_ff == PDMC_SETTLE && settle_cnt_ff != '0) begin
            settle_cnt_ff <= settle_cnt_ff - SETTLE_W'(1);
        end
    end

    // interrupt mask flag captured at the sleep instruction
    always_ff @(posedge aclk) begin
        if (!aresetn) mask_at_sleep_ff <= 1'b0;
        else if (state_ff == PDMC_RUN && sleep_exec) mask_at_sleep_ff <= cpu_mask_flag;
    end

    // ------------------------------------------------------------------
    // chip gating outputs
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl       <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1,
                            periph_init: 1'b0, cpu_regs_lost: 1'b0, io_hiz: 1'b0,
                            ram_hold: 1'b0};
            wake_irq   <= 1'b0;
            wake_reset <= 1'b0;
        end else begin
            ctrl.cpu_clk_en    <= (nxt_state == PDMC_RUN);
            ctrl.periph_clk_en <= (nxt_state == PDMC_RUN) || (nxt_state == PDMC_SLEEP);
            ctrl.osc_en        <= (nxt_state != PDMC_SSTBY) && (nxt_state != PDMC_HSTBY);
            ctrl.periph_init   <= (nxt_state == PDMC_SSTBY) || (nxt_state == PDMC_HSTBY);
            ctrl.cpu_regs_lost <= (nxt_state == PDMC_HSTBY);
            ctrl.io_hiz        <= (nxt_state == PDMC_HSTBY);
            ctrl.ram_hold      <= (nxt_state != PDMC_RUN) && (nxt_state != PDMC_RESET);
            // cpu resumes into its interrupt sequence, then the next instruction
            wake_irq   <= (nxt_state == PDMC_RUN)
                       && (state_ff == PDMC_SLEEP || state_ff == PDMC_SETTLE);
            wake_reset <= (state_ff == PDMC_RESET) && (nxt_state == PDMC_RUN);
        end
    end
    assign mode = state_ff;

    // ------------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
    assign wr_fire       = aw_hold_ff && w_hold_ff && !bvalid_ff;

    // address and data are captured independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awaddr_ff  <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_ff <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= AXI_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (awaddr_ff[15:2] == SYSCTL_OFFSET[15:2]
                          || awaddr_ff[15:2] == STATUS_OFFSET[15:2]) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // system control register; only byte lane 0 carries it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_pin_en_ff    <= SYSCTL_RESET[STANDBY_PIN_EN_POS];
            settle_sel_ff <= SYSCTL_RESET[SETTLE_HI_POS:SETTLE_LO_POS];
            nmi_edge_ff   <= SYSCTL_RESET[NMI_EDGE_POS];
            host_if_ff    <= SYSCTL_RESET[HOST_IF_POS];
            ram_en_ff     <= SYSCTL_RESET[RAM_EN_POS];
        end else if (wr_fire && wstrb_ff[0] && awaddr_ff[15:2] == SYSCTL_OFFSET[15:2]) begin
            // hardware never clears the standby bit on wake
            standby_pin_en_ff    <= wdata_ff[STANDBY_PIN_EN_POS];
            settle_sel_ff <= wdata_ff[SETTLE_HI_POS:SETTLE_LO_POS];
            nmi_edge_ff   <= wdata_ff[NMI_EDGE_POS];
            host_if_ff    <= wdata_ff[HOST_IF_POS];
            ram_en_ff     <= wdata_ff[RAM_EN_POS];
        end
    end

    // read-only reset-source flag: set whenever the reset state is entered (reset pin or hardware standby exit), cleared never
    always_ff @(posedge aclk) begin
        if (!aresetn) ext_rst_ff <= SYSCTL_RESET[EXT_RST_POS];
        else if (state_ff == PDMC_RESET) ext_rst_ff <= 1'b1;
    end

    // ------------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------------
    always_comb begin
        sysctl_rd = '0;
        sysctl_rd[STANDBY_PIN_EN_POS]                 = standby_pin_en_ff;
        sysctl_rd[SETTLE_HI_POS:SETTLE_LO_POS] = settle_sel_ff;
        sysctl_rd[EXT_RST_POS]                 = ext_rst_ff;
        sysctl_rd[NMI_EDGE_POS]                = nmi_edge_ff;
        sysctl_rd[HOST_IF_POS]                 = host_if_ff;
        sysctl_rd[RAM_EN_POS]                  = ram_en_ff;
    end

    assign s_axi_arready = !rvalid_ff;
    // read data registered, one cycle after address acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= AXI_OKAY;
            if (s_axi_araddr[15:2] == SYSCTL_OFFSET[15:2]) begin
                rdata_ff <= {24'h000000, sysctl_rd};
            end else if (s_axi_araddr[15:2] == STATUS_OFFSET[15:2]) begin
                rdata_ff <= {26'h0000000, state_ff};
            end else begin
                rdata_ff <= '0;
                rresp_ff <= AXI_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_sleep_entry;
        @(posedge aclk) disable iff (!aresetn)
        (state_ff == PDMC_RUN && sleep_exec && standby_pin_n && reset_pin_n && !standby_pin_en_ff)
        |=> state_ff == PDMC_SLEEP ##0 !ctrl.cpu_clk_en && ctrl.periph_clk_en;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");
    property p_sstby_entry;
        @(posedge aclk) disable iff (!aresetn)
        (state_ff == PDMC_RUN && sleep_exec && standby_pin_n && reset_pin_n && standby_pin_en_ff)
        |=> state_ff == PDMC_SSTBY && !ctrl.osc_en && ctrl.periph_init;
    endproperty
    a_sstby_entry: assert property (p_sstby_entry) else $error("standby entry wrong");
    property p_hstby_force;
        @(posedge aclk) disable iff (!aresetn)
        !standby_pin_n |=> state_ff == PDMC_HSTBY && ctrl.io_hiz && ctrl.cpu_regs_lost;
    endproperty
    a_hstby_force: assert property (p_hstby_force) else $error("hw standby not forced");
    property p_standby_pin_bit_kept;
        @(posedge aclk) disable iff (!aresetn)
        (state_ff == PDMC_SETTLE && nxt_state == PDMC_RUN) |=> standby_pin_en_ff;
    endproperty
    a_standby_pin_bit_kept: assert property (p_standby_pin_bit_kept) else $error("standby bit lost");
    property p_settle_load;
        @(posedge aclk) disable iff (!aresetn)
        (state_ff == PDMC_SSTBY && nxt_state == PDMC_SETTLE && settle_sel_ff == 3'h0)
        |=> settle_cnt_ff == SETTLE_W'(SETTLE_STATES_0 - 1);
    endproperty
    a_settle_load: assert property (p_settle_load) else $error("settle load wrong");
    property p_settle_gate;
        @(posedge aclk) disable iff (!aresetn)
        (state_ff == PDMC_SETTLE && $past(state_ff) == PDMC_SETTLE)
        |-> !ctrl.cpu_clk_en && !ctrl.periph_clk_en && ctrl.osc_en;
    endproperty
    a_settle_gate: assert property (p_settle_gate) else $error("clock leaked in settle");
    property p_masked_sleep;
        @(posedge aclk) disable iff (!aresetn)
        (state_ff == PDMC_SLEEP && mask_at_sleep_ff && !wake_src.nmi
         && standby_pin_n && reset_pin_n) |=> state_ff == PDMC_SLEEP;
    endproperty
    a_masked_sleep: assert property (p_masked_sleep) else $error("masked sleep woke");
    property p_sleep_reset;
        @(posedge aclk) disable iff (!aresetn)
        (state_ff == PDMC_SLEEP && !reset_pin_n && standby_pin_n) |=> state_ff == PDMC_RESET;
    endproperty
    a_sleep_reset: assert property (p_sleep_reset) else $error("reset pin ignored");
    property p_sleep_irq;
        @(posedge aclk) disable iff (!aresetn)
        (state_ff == PDMC_SLEEP && wake_src.nmi && standby_pin_n && reset_pin_n)
        |=> state_ff == PDMC_RUN && wake_irq;
    endproperty
    a_sleep_irq: assert property (p_sleep_irq) else $error("nmi did not wake");
endmodule : pdmc_top

// ===== rtl/pdmc_pkg.sv
// package for the power-down mode controller: register map, fields, states, timing
package pdmc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [15:0] SYSCTL_OFFSET   = 16'hffc4;
    localparam logic [7:0]  SYSCTL_RESET    = 8'h09;
    localparam int          STANDBY_PIN_EN_POS     = 7;
    localparam int          SETTLE_HI_POS   = 6;
    localparam int          SETTLE_LO_POS   = 4;
    localparam int          EXT_RST_POS     = 3;
    localparam int          NMI_EDGE_POS    = 2;
    localparam int          HOST_IF_POS     = 1;
    localparam int          RAM_EN_POS      = 0;
    // own status register: current mode in low bits
    localparam logic [15:0] STATUS_OFFSET   = 16'hffc8;

    // ------------------------------------------------------------------
    // settling times in states (one state is one aclk cycle)
    // ------------------------------------------------------------------
    localparam int          SETTLE_STATES_0 = 8192;
    localparam int          SETTLE_STATES_1 = 16384;
    localparam int          SETTLE_STATES_2 = 32768;
    localparam int          SETTLE_STATES_3 = 65536;
    localparam int          SETTLE_STATES_4 = 131072;
    localparam int          SETTLE_W        = 18;

    // ------------------------------------------------------------------
    // axi responses
    // ------------------------------------------------------------------
    localparam logic [1:0]  AXI_OKAY        = 2'b00;
    localparam logic [1:0]  AXI_SLVERR      = 2'b10;

    // ------------------------------------------------------------------
    // mode states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        PDMC_RUN    = 6'b000001,
        PDMC_SLEEP  = 6'b000010,
        PDMC_SSTBY  = 6'b000100,
        PDMC_SETTLE = 6'b001000,
        PDMC_HSTBY  = 6'b010000,
        PDMC_RESET  = 6'b100000
    } pdmc_state_e;

    // wake sources from the interrupt side
    typedef struct packed {
        logic       nmi;
        logic [2:0] ext_irq;
        logic [7:0] key_sense;
        logic       periph_irq;
    } pdmc_wake_s;

    // gating outputs toward the rest of the chip
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_en;
        logic periph_init;
        logic cpu_regs_lost;
        logic io_hiz;
        logic ram_hold;
    } pdmc_ctrl_s;

endpackage : pdmc_pkg

// ===== bench/pdmc_env_model.sv
// far-side model: cpu sleep requests, gated interrupt sources and the two pins
`timescale 1ns/10ps
module pdmc_env_model
    import pdmc_pkg::*;
#(
    parameter int HOLD = 16
) (
    // clock
    input  wire logic aclk,
    // cpu, interrupt and pin side
    output logic       sleep_exec,
    output logic       cpu_mask_flag,
    output pdmc_wake_s wake_src,
    output logic       standby_pin_n,
    output logic       reset_pin_n
);
    // idle levels: no request, pins released high
    initial begin
        sleep_exec    = 1'b0;
        cpu_mask_flag = 1'b0;
        wake_src      = '0;
        standby_pin_n = 1'b1;
        reset_pin_n   = 1'b1;
    end
    // one-cycle sleep instruction, mask flag sampled with it
    task automatic sleep_op(input logic m);
        @(posedge aclk);
        sleep_exec    <= 1'b1;
        cpu_mask_flag <= m;
        @(posedge aclk);
        sleep_exec    <= 1'b0;
    endtask : sleep_op
    // one-cycle request; disabled sources are simply never raised
    task automatic irq(input pdmc_wake_s w);
        @(posedge aclk);
        wake_src <= w;
        @(posedge aclk);
        wake_src <= '0;
    endtask : irq
    // both pins move at one edge, the next edge samples them
    task automatic pins(input logic s, input logic r);
        @(posedge aclk);
        standby_pin_n <= s;
        reset_pin_n   <= r;
        @(posedge aclk);
    endtask : pins
    // standby pin rises first, reset kept low while the clock settles
    task automatic hstby_exit();
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        repeat (HOLD) @(posedge aclk);
    endtask : hstby_exit
endmodule : pdmc_env_model

// ===== bench/power_down_mode_control_tb_top.sv
// self-checking bench for the power-down mode controller
`timescale 1ns/10ps
module power_down_mode_control_tb_top;
    import pdmc_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid, wake_irq, wake_reset;
    logic [1:0]  bresp, rresp;
    logic        sleep_exec, cpu_mask_flag, standby_pin_n, reset_pin_n;
    pdmc_wake_s  wake_src;
    pdmc_ctrl_s  ctrl;
    pdmc_state_e mode;
    int          mismatches, check_count, cyc;

    pdmc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sleep_exec(sleep_exec), .cpu_mask_flag(cpu_mask_flag),
        .wake_irq(wake_irq), .wake_reset(wake_reset), .wake_src(wake_src),
        .standby_pin_n(standby_pin_n), .reset_pin_n(reset_pin_n), .ctrl(ctrl), .mode(mode));
    pdmc_env_model host (.aclk(aclk), .sleep_exec(sleep_exec),
        .cpu_mask_flag(cpu_mask_flag), .wake_src(wake_src),
        .standby_pin_n(standby_pin_n), .reset_pin_n(reset_pin_n));

    // --------------------------------------------------------------
    // clock, watchdog, shared tasks
    // --------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // three soft-standby settles, one at the doubled select, dominate the run
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 50000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // requests raised at an edge; readies and answers taken at the rising edge
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'h1;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        #1;
    endtask : rd
    task automatic step(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : step
    // register reset value, read-only flag, unmapped place
    task automatic run_regs();
        logic [31:0] d;
        logic [1:0]  r;
        rd(SYSCTL_OFFSET, d, r);
        chk(d, 32'h09);
        rd(16'hff00, d, r);
        chk({d[29:0], r}, {30'h0, AXI_SLVERR});
        wr(16'hff00, 32'h000000ff, r);
        chk(r, AXI_SLVERR);
        wr(SYSCTL_OFFSET, 32'h80, r);
        chk(r, AXI_OKAY);
        rd(SYSCTL_OFFSET, d, r);
        chk(d, 32'h88);
        rd(STATUS_OFFSET, d, r);
        chk(d, {26'h0, PDMC_RUN});
    endtask : run_regs
    // soft standby left by each external source, settle counted exactly
    task automatic run_sstby();
        pdmc_wake_s  src [3];
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        src = '{default: '0};
        src[0].nmi = 1'b1;
        src[1].ext_irq = 3'h4;
        src[2].key_sense = 8'h80;
        for (int i = 0; i < 3; i++) begin
            if (i == 2) wr(SYSCTL_OFFSET, 32'h90, r);
            host.sleep_op(1'b0);
            #1;
            chk(mode, PDMC_SSTBY);
            chk({ctrl.cpu_clk_en, ctrl.periph_clk_en, ctrl.periph_init}, 3'b001);
            chk({ctrl.osc_en, ctrl.ram_hold}, 2'b01);
            host.irq(src[i]);
            #1;
            chk(mode, PDMC_SETTLE);
            chk({ctrl.osc_en, ctrl.cpu_clk_en, ctrl.periph_clk_en}, 3'b100);
            n = 0;
            while (mode === PDMC_SETTLE) begin
                step(1);
                n++;
            end
            chk(n, (i == 2) ? SETTLE_STATES_1 : SETTLE_STATES_0);
            chk({mode, wake_irq}, {PDMC_RUN, 1'b1});
        end
        rd(SYSCTL_OFFSET, d, r);
        chk(d, 32'h98);
    endtask : run_sstby
    // sleep: peripheral wake without settle, masked wake only by nmi
    task automatic run_sleep();
        pdmc_wake_s w;
        logic [1:0] r;
        wr(SYSCTL_OFFSET, 32'h00, r);
        host.sleep_op(1'b0);
        #1;
        chk({mode, ctrl.cpu_clk_en, ctrl.periph_clk_en}, {PDMC_SLEEP, 2'b01});
        step(4);
        chk(mode, PDMC_SLEEP);
        w = '0;
        w.periph_irq = 1'b1;
        host.irq(w);
        #1;
        chk({mode, wake_irq}, {PDMC_RUN, 1'b1});
        host.sleep_op(1'b1);
        w = '0;
        w.ext_irq = 3'h1;
        host.irq(w);
        #1;
        chk(mode, PDMC_SLEEP);
        w = '0;
        w.nmi = 1'b1;
        host.irq(w);
        #1;
        chk(mode, PDMC_RUN);
    endtask : run_sleep
    // pins during sleep: reset state, hardware standby and its exit
    task automatic run_pins();
        host.sleep_op(1'b0);
        host.pins(1'b1, 1'b0);
        #1;
        chk(mode, PDMC_RESET);
        host.pins(1'b1, 1'b1);
        #1;
        chk({mode, wake_reset}, {PDMC_RUN, 1'b1});
        host.sleep_op(1'b0);
        host.pins(1'b0, 1'b1);
        #1;
        chk(mode, PDMC_HSTBY);
        chk({ctrl.io_hiz, ctrl.cpu_regs_lost}, 2'b11);
        host.hstby_exit();
        #1;
        chk(mode, PDMC_RESET);
        host.pins(1'b1, 1'b1);
        #1;
        chk({mode, wake_reset}, {PDMC_RUN, 1'b1});
    endtask : run_pins
    // main sequence
    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        arvalid = 1'b0;
        rready  = 1'b0;
        awaddr  = '0;
        araddr  = '0;
        wdata   = '0;
        wstrb   = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        step(1);
        run_regs();
        run_sstby();
        run_sleep();
        run_pins();
        report_and_stop();
    end
endmodule : power_down_mode_control_tb_top
